//--- car_pkg.sv
package car_pkg;
  // Register byte offsets
  localparam logic [7:0] OFS_CTRL      = 8'h00;
  localparam logic [7:0] OFS_ROUTE     = 8'h04;
  localparam logic [7:0] OFS_CLIP      = 8'h08;
  localparam logic [7:0] OFS_FAILTIME  = 8'h0C;
  localparam logic [7:0] OFS_AUX       = 8'h10;
  localparam logic [7:0] OFS_STATUS    = 8'h14;
  localparam logic [7:0] OFS_IRQ_STAT  = 8'h18;
  localparam logic [7:0] OFS_IRQ_EN    = 8'h1C;
  localparam logic [7:0] OFS_IRQ_CLR   = 8'h20;
  // CTRL field positions
  localparam int CTRL_LOWLAT   = 0;
  localparam int CTRL_FS48     = 1;
  localparam int CTRL_ENCMONO  = 2;
  localparam int CTRL_MONOSUM  = 3;
  localparam int CTRL_DECMONO  = 4;
  localparam int CTRL_MONOFILL = 5;
  localparam int CTRL_PHYALM   = 6;
  localparam int CTRL_DNSALM   = 7;
  localparam int CTRL_IPALM    = 8;
  localparam int CTRL_CLKMODE  = 9;   // 2 bits
  localparam int CTRL_NTPEN    = 11;
  // ROUTE field positions
  localparam int ROUTE_ADV     = 0;
  localparam int ROUTE_SELC    = 1;   // 2 bits
  localparam int ROUTE_SELD    = 3;   // 2 bits
  // AUX field positions
  localparam int AUX_BAUD      = 0;   // 3 bits
  localparam int AUX_EMBED     = 3;
  // Reset values: physical and IP alarms on, dynamic name alarm off
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0142;
  localparam logic [31:0] CLIP_RESET  = 32'h0000_00F0;   // 24.0 dBu in 0.1 dB steps
  localparam logic [31:0] FAIL_RESET  = 32'h0000_4E20;   // Fail time in cycles
  localparam logic [2:0]  BAUD_MAX_EMBED = 3'h3;         // Index of 9600 baud
  localparam logic [2:0]  BAUD_MAX       = 3'h7;         // Index of 115200 baud
  // Interrupt bit positions
  localparam int IRQ_SYNC = 0;
  localparam int IRQ_IP   = 1;
  localparam int IRQ_PHY  = 2;
  localparam int IRQ_DNS  = 3;
  localparam int IRQ_W    = 4;
  localparam int SW       = 24;       // Extended sample width for sums

  typedef enum logic [1:0] {
    CLK_ASYM   = 2'h0,
    CLK_MASTER = 2'h1,
    CLK_SYSTIM = 2'h2,
    CLK_RSVD   = 2'h3
  } car_clkmode_t;

  typedef enum logic [1:0] {
    SRC_LEFT  = 2'h0,
    SRC_RIGHT = 2'h1,
    SRC_MIX   = 2'h2,
    SRC_RSV   = 2'h3
  } car_outsel_t;

  // Halved sum at extended width, no overflow
  function automatic logic [SW-1:0] car_half_sum(input logic [SW-1:0] a, input logic [SW-1:0] b);
    logic [SW:0] s;
    s = {a[SW-1], a} + {b[SW-1], b};
    return s[SW:1];
  endfunction : car_half_sum
endpackage : car_pkg

//--- car_cfg_if.sv
`timescale 1ns/1ps
interface car_cfg_if;
  import car_pkg::*;
  logic [31:0] failTime;
  logic        syncFault;
  logic        syncAlarm;
  modport ctrl (output failTime, output syncFault, input syncAlarm);
  modport qual (input failTime, input syncFault, output syncAlarm);
endinterface : car_cfg_if

//--- car_sync_qual.sv
`timescale 1ns/1ps
module car_sync_qual
  import car_pkg::*;
(
  // Clock and reset
  input  wire logic sys_clk,
  input  wire logic arst_n,
  // Configuration and alarm
  car_cfg_if.qual   cfg
);
  logic [31:0] cntReg, cntNext;
  logic        almReg, almNext;

  // Count continuous fault time; any gap restarts it
  always_comb begin
    cntNext = cntReg;
    almNext = 1'b0;
    if (!cfg.syncFault) begin
      cntNext = 32'h0000_0000;
    end else if (cntReg >= cfg.failTime) begin
      almNext = 1'b1;
    end else begin
      cntNext = cntReg + 32'h0000_0001;
    end
  end

  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      cntReg <= 32'h0000_0000;
      almReg <= 1'b0;
    end else begin
      cntReg <= cntNext;
      almReg <= almNext;
    end
  end

  assign cfg.syncAlarm = almReg;

  a_sync_needs_fault: assert property (@(posedge sys_clk) disable iff (!arst_n)
    almReg |-> $past(cfg.syncFault)) else $error("sync alarm without fault");
endmodule : car_sync_qual

//--- car_route_alarm.sv
`timescale 1ns/1ps
// Overview of operation
// - Clip level register sets analog level equal to full scale, default 24 dBu.
// - Encoder bypasses input rate converter when low latency on and rate is 48 kHz.
// - Any non-48 kHz audio mode forces low latency off whatever the enable.
// - Encoder mono source, left or halved sum, applies only with mono algorithm.
// - Decoder mono output setting applies only to a mono stream.
// - Mono output drives left only; mono-fill also copies it to right.
// - Sync alarm raised only after fault persists the full configured fail time.
// - Asymmetric mode: encoder internal clock, decoder steers oscillator from packets.
// - System-time mode derives clock from system time; without network time, acts as master.
// - Routing disabled sends decoded left and right straight to outputs C and D, except with decoder mono output on a mono stream.
// - Routing enabled lets C and D each pick left, right or halved sum.
// - Decoder halved sum is formed after decoding and leaves stream untouched.
// - Empty de-jitter buffer signals IP connection loss unless that alarm is disabled.
// - Physical link loss raises nothing while the physical alarm is disabled.
// - Dynamic name alarm is off after reset and never raised while off.
// - Baud rate spans 1200 to 115200; embedded mode limits it to 9600.
// - Auxiliary data is duplex only as separate stream; embedded is one way.
// - Mono-fill and advanced routing are never active together.
module car_route_alarm
  import car_pkg::*;
(
  // Clock and reset
  input  wire logic            sys_clk,
  input  wire logic            arst_n,
  // APB slave
  input  wire logic            psel,
  input  wire logic            penable,
  input  wire logic            pwrite,
  input  wire logic [7:0]      paddr,
  input  wire logic [31:0]     pwdata,
  output logic      [31:0]     prdata,
  output logic                 pready,
  output logic                 pslverr,
  // Encoder audio in
  input  wire logic [SW-1:0]   encLeft,
  input  wire logic [SW-1:0]   encRight,
  output logic      [SW-1:0]   encMonoSrc,
  output logic                 srcBypass,
  // Decoder audio in and out
  input  wire logic [SW-1:0]   decLeft,
  input  wire logic [SW-1:0]   decRight,
  input  wire logic            decMonoStream,
  output logic      [SW-1:0]   outC,
  output logic      [SW-1:0]   outD,
  // Clocking selection
  output logic                 useInternalClk,
  output logic                 vcxoFromPackets,
  output logic                 clkFromSysTime,
  // Auxiliary data
  output logic      [2:0]      auxBaud,
  output logic                 auxRxEnable,
  // Alarm sources
  input  wire logic            syncFault,
  input  wire logic            jitterBufEmpty,
  input  wire logic            phyLinkLost,
  input  wire logic            dnsLost,
  output logic                 irq
);
  logic [31:0] ctrlReg, ctrlNext;
  logic [4:0]  routeReg, routeNext;
  logic [31:0] clipReg, clipNext;
  logic [31:0] failReg, failNext;
  logic [3:0]  auxReg, auxNext;
  logic [IRQ_W-1:0] stReg, stNext;
  logic [IRQ_W-1:0] enReg, enNext;
  logic [31:0] rdReg, rdNext;
  logic        rdyReg, rdyNext;
  logic        errReg, errNext;
  logic        irqReg, irqNext;
  logic [SW-1:0] encMonoReg, encMonoNext, cReg, cNext, dReg, dNext;
  logic        bypReg, bypNext;
  logic [2:0]  clkSelReg, clkSelNext;
  logic [2:0]  baudReg, baudNext;
  logic        auxRxReg, auxRxNext;
  logic [SW-1:0] decMix;
  logic        wrEn, rdEn, mapped;
  logic [IRQ_W-1:0] events;
  car_clkmode_t clkMode;

  car_cfg_if cfgBus ();

  // Fault persistence timer
  car_sync_qual uQual (
    .sys_clk (sys_clk),
    .arst_n  (arst_n),
    .cfg     (cfgBus)
  );
  assign cfgBus.failTime  = failReg;
  assign cfgBus.syncFault = syncFault;

  // Zero-wait APB: answer in the access cycle
  // Write lands at the access edge where the master sees pready high
  assign wrEn = psel && penable && pwrite && rdyReg;
  assign rdEn = psel && !penable && !pwrite;
  always_comb begin
    unique case (paddr)
      OFS_CTRL, OFS_ROUTE, OFS_CLIP, OFS_FAILTIME, OFS_AUX,
      OFS_STATUS, OFS_IRQ_STAT, OFS_IRQ_EN, OFS_IRQ_CLR: mapped = 1'b1;
      default: mapped = 1'b0;
    endcase
  end

  // Register writes and bus answer
  always_comb begin
    ctrlNext  = ctrlReg;
    routeNext = routeReg;
    clipNext  = clipReg;
    failNext  = failReg;
    auxNext   = auxReg;
    enNext    = enReg;
    rdNext    = rdReg;
    rdyNext   = psel && !penable;
    errNext   = psel && !penable && !mapped;
    if (wrEn) begin
      unique case (paddr)
        OFS_CTRL:     ctrlNext = {20'h0_0000, pwdata[11:0]};
        OFS_ROUTE: begin
          routeNext = pwdata[4:0];
          // Routing wins; mono-fill dropped so both never stand together
          if (pwdata[ROUTE_ADV]) ctrlNext[CTRL_MONOFILL] = 1'b0;
        end
        OFS_CLIP:     clipNext = pwdata;
        OFS_FAILTIME: failNext = pwdata;
        OFS_AUX: begin
          auxNext = pwdata[3:0];
          // Clamp rate to embedded ceiling
          if (pwdata[AUX_EMBED] && pwdata[2:0] > BAUD_MAX_EMBED) auxNext[2:0] = BAUD_MAX_EMBED;
        end
        OFS_IRQ_EN:   enNext = pwdata[IRQ_W-1:0];
        default: ;
      endcase
    end
    if (wrEn && paddr == OFS_CTRL && pwdata[CTRL_MONOFILL] && routeReg[ROUTE_ADV]) begin
      ctrlNext[CTRL_MONOFILL] = 1'b0;
    end
    if (rdEn) begin
      unique case (paddr)
        OFS_CTRL:     rdNext = ctrlReg;
        OFS_ROUTE:    rdNext = {27'h000_0000, routeReg};
        OFS_CLIP:     rdNext = clipReg;
        OFS_FAILTIME: rdNext = failReg;
        OFS_AUX:      rdNext = {28'h000_0000, auxReg};
        OFS_STATUS:   rdNext = {27'h000_0000, auxRxReg, clkSelReg, bypReg};
        OFS_IRQ_STAT: rdNext = {28'h000_0000, stReg};
        OFS_IRQ_EN:   rdNext = {28'h000_0000, enReg};
        default:      rdNext = 32'h0000_0000;
      endcase
    end
  end

  // Gated alarm events and sticky status; set beats clear
  always_comb begin
    events = '0;
    events[IRQ_SYNC] = cfgBus.syncAlarm;
    events[IRQ_IP]   = jitterBufEmpty && ctrlReg[CTRL_IPALM];
    events[IRQ_PHY]  = phyLinkLost && ctrlReg[CTRL_PHYALM];
    events[IRQ_DNS]  = dnsLost && ctrlReg[CTRL_DNSALM];
    stNext = stReg;
    if (wrEn && paddr == OFS_IRQ_CLR) stNext = stNext & ~pwdata[IRQ_W-1:0];
    stNext  = stNext | events;
    irqNext = |(stNext & enNext);
  end

  // Audio path and mode decode
  assign clkMode = car_clkmode_t'(ctrlReg[CTRL_CLKMODE +: 2]);
  assign decMix  = car_half_sum(decLeft, decRight);
  always_comb begin
    // Low latency only counts at 48 kHz
    bypNext = ctrlReg[CTRL_LOWLAT] && ctrlReg[CTRL_FS48];
    encMonoNext = encLeft;
    if (ctrlReg[CTRL_ENCMONO] && ctrlReg[CTRL_MONOSUM]) begin
      encMonoNext = car_half_sum(encLeft, encRight);
    end
    cNext = decLeft;
    dNext = decRight;
    if (routeReg[ROUTE_ADV]) begin
      unique case (car_outsel_t'(routeReg[ROUTE_SELC +: 2]))
        SRC_RIGHT: cNext = decRight;
        SRC_MIX:   cNext = decMix;
        default:   cNext = decLeft;
      endcase
      unique case (car_outsel_t'(routeReg[ROUTE_SELD +: 2]))
        SRC_LEFT: dNext = decLeft;
        SRC_MIX:  dNext = decMix;
        default:  dNext = decRight;
      endcase
    end else if (decMonoStream && ctrlReg[CTRL_DECMONO]) begin
      // Mono lands on left; right idles unless filled
      cNext = decLeft;
      dNext = ctrlReg[CTRL_MONOFILL] ? decLeft : '0;
    end
    unique case (clkMode)
      CLK_ASYM:   clkSelNext = 3'b011;
      CLK_SYSTIM: clkSelNext = ctrlReg[CTRL_NTPEN] ? 3'b100 : 3'b001;
      default:    clkSelNext = 3'b001;
    endcase
    baudNext  = auxReg[2:0];
    auxRxNext = !auxReg[AUX_EMBED];
  end

  // All state registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      ctrlReg    <= CTRL_RESET;
      routeReg   <= 5'h00;
      clipReg    <= CLIP_RESET;
      failReg    <= FAIL_RESET;
      auxReg     <= 4'h0;
      stReg      <= '0;
      enReg      <= '0;
      rdReg      <= 32'h0000_0000;
      rdyReg     <= 1'b0;
      errReg     <= 1'b0;
      irqReg     <= 1'b0;
      encMonoReg <= '0;
      cReg       <= '0;
      dReg       <= '0;
      bypReg     <= 1'b0;
      clkSelReg  <= 3'b011;
      baudReg    <= 3'h0;
      auxRxReg   <= 1'b1;
    end else begin
      ctrlReg    <= ctrlNext;
      routeReg   <= routeNext;
      clipReg    <= clipNext;
      failReg    <= failNext;
      auxReg     <= auxNext;
      stReg      <= stNext;
      enReg      <= enNext;
      rdReg      <= rdNext;
      rdyReg     <= rdyNext;
      errReg     <= errNext;
      irqReg     <= irqNext;
      encMonoReg <= encMonoNext;
      cReg       <= cNext;
      dReg       <= dNext;
      bypReg     <= bypNext;
      clkSelReg  <= clkSelNext;
      baudReg    <= baudNext;
      auxRxReg   <= auxRxNext;
    end
  end

  // Outputs straight from flops
  assign prdata          = rdReg;
  assign pready          = rdyReg;
  assign pslverr         = errReg;
  assign irq             = irqReg;
  assign encMonoSrc      = encMonoReg;
  assign srcBypass       = bypReg;
  assign outC            = cReg;
  assign outD            = dReg;
  assign useInternalClk  = clkSelReg[0];
  assign vcxoFromPackets = clkSelReg[1];
  assign clkFromSysTime  = clkSelReg[2];
  assign auxBaud         = baudReg;
  assign auxRxEnable     = auxRxReg;

  // Checks
  a_bypass_needs48: assert property (@(posedge sys_clk) disable iff (!arst_n)
    srcBypass |-> $past(ctrlReg[CTRL_FS48])) else $error("bypass outside 48 kHz");
  a_ip_alarm_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (jitterBufEmpty && ctrlReg[CTRL_IPALM]) |=> stReg[IRQ_IP]) else $error("ip loss not flagged");
  a_phy_alarm_off: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!ctrlReg[CTRL_PHYALM] && !stReg[IRQ_PHY]) |=> !stReg[IRQ_PHY])
    else $error("phy alarm while disabled");
  a_dns_alarm_off: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!ctrlReg[CTRL_DNSALM] && !stReg[IRQ_DNS] && !(wrEn && paddr == OFS_CTRL)) |=> !stReg[IRQ_DNS])
    else $error("dns alarm while disabled");
  a_fill_route_excl: assert property (@(posedge sys_clk) disable iff (!arst_n)
    !(ctrlReg[CTRL_MONOFILL] && routeReg[ROUTE_ADV])) else $error("mono-fill with routing");
  a_embed_baud_cap: assert property (@(posedge sys_clk) disable iff (!arst_n)
    auxReg[AUX_EMBED] |-> auxReg[2:0] <= BAUD_MAX_EMBED) else $error("embedded baud too high");
  a_embed_simplex: assert property (@(posedge sys_clk) disable iff (!arst_n)
    auxReg[AUX_EMBED] |=> !auxRxEnable) else $error("embedded duplex");
  a_direct_route: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!routeReg[ROUTE_ADV] && !decMonoStream) |=> outC == $past(decLeft) && outD == $past(decRight))
    else $error("direct route broken");
  a_ntp_off_master: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (clkMode == CLK_SYSTIM && !ctrlReg[CTRL_NTPEN]) |=> useInternalClk && !clkFromSysTime)
    else $error("systime without ntp not master");
  c_ip_loss: cover property (@(posedge sys_clk) disable iff (!arst_n) stReg[IRQ_IP] && irq);
  c_sync_alarm: cover property (@(posedge sys_clk) disable iff (!arst_n) cfgBus.syncAlarm);
  c_route_mix: cover property (@(posedge sys_clk) disable iff (!arst_n)
    routeReg[ROUTE_ADV] && routeReg[ROUTE_SELC +: 2] == 2'h2);
endmodule : car_route_alarm

//--- car_net_model.sv
`timescale 1ns/1ps
// Network side: delivers decoded samples and the de-jitter buffer state
module car_net_model
  import car_pkg::*;
(
  // Clock and reset
  input  wire logic          sys_clk,
  input  wire logic          arst_n,
  // Commands from the bench
  input  wire logic [SW-1:0] leftIn,
  input  wire logic [SW-1:0] rightIn,
  input  wire logic          monoIn,
  input  wire logic          starveIn,
  // Toward the decoder
  output logic      [SW-1:0] decLeft,
  output logic      [SW-1:0] decRight,
  output logic               decMonoStream,
  output logic               jitterBufEmpty
);
  // Packets land one cycle after the bench asks; starving empties the buffer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      decLeft        <= '0;
      decRight       <= '0;
      decMonoStream  <= 1'b0;
      jitterBufEmpty <= 1'b0;
    end else begin
      decLeft        <= leftIn;
      decRight       <= rightIn;
      decMonoStream  <= monoIn;
      jitterBufEmpty <= starveIn;
    end
  end
endmodule : car_net_model

//--- car_route_alarm_tb.sv
`timescale 1ns/1ps
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin errors++; \
  $display("unexpected at %0t: got %h expected %h", $time, g, e); end end
module car_route_alarm_tb;
  import car_pkg::*;
  logic          sys_clk = 0;
  logic          arst_n  = 0;
  logic          psel = 0, penable = 0, pwrite = 0;
  logic [7:0]    paddr   = '0;
  logic [31:0]   pwdata  = '0, prdata;
  logic          pready, pslverr, irq, srcBypass, auxRxEnable, decMonoStream, jitterBufEmpty;
  logic [SW-1:0] encLeft = '0, encRight = '0, netL = '0, netR = '0;
  logic [SW-1:0] encMonoSrc, decLeft, decRight, outC, outD;
  logic          netMono = 0, useInternalClk, vcxoFromPackets, clkFromSysTime;
  logic [2:0]    auxBaud;
  logic [3:0]    ev = '0;   // Event levels: sync, starve, phy, dns
  int            errors = 0, checks = 0;

  // 20 MHz clock
  always #25 sys_clk = ~sys_clk;

  car_net_model i_net (.sys_clk(sys_clk), .arst_n(arst_n), .leftIn(netL), .rightIn(netR), .monoIn(netMono),
    .starveIn(ev[1]), .decLeft(decLeft), .decRight(decRight), .decMonoStream(decMonoStream),
    .jitterBufEmpty(jitterBufEmpty));
  car_route_alarm i_dut (.sys_clk(sys_clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .encLeft(encLeft),
    .encRight(encRight), .encMonoSrc(encMonoSrc), .srcBypass(srcBypass), .decLeft(decLeft),
    .decRight(decRight), .decMonoStream(decMonoStream), .outC(outC), .outD(outD),
    .useInternalClk(useInternalClk), .vcxoFromPackets(vcxoFromPackets), .clkFromSysTime(clkFromSysTime),
    .auxBaud(auxBaud), .auxRxEnable(auxRxEnable), .syncFault(ev[0]), .jitterBufEmpty(jitterBufEmpty),
    .phyLinkLost(ev[2]), .dnsLost(ev[3]), .irq(irq));

  task automatic finish_test();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask : finish_test

  // One APB transfer; holds the request until pready is seen at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    int n;
    @(posedge sys_clk);
    psel <= 1; penable <= 0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge sys_clk);
    penable <= 1;
    n = 0;
    do begin @(posedge sys_clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20) begin errors++; $display("unexpected at %0t: no pready", $time); finish_test(); end
    q = prdata; e = pslverr;
    psel <= 0; penable <= 0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q; logic e;
    apb(1'b1, a, d, q, e);
    repeat (3) @(posedge sys_clk);   // Let registered outputs follow
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [31:0] x, input logic xe = 1'b0);
    logic [31:0] q; logic e;
    apb(1'b0, a, 32'h0000_0000, q, e);
    `CHK(q, x)
    `CHK(e, xe)
  endtask : rd

  // Hold event levels for n cycles, then release
  task automatic hold(input logic [3:0] v, input int n);
    @(posedge sys_clk); ev <= v;
    repeat (n) @(posedge sys_clk);
    ev <= '0;
    repeat (3) @(posedge sys_clk);
  endtask : hold

  task automatic t_reset();
    `CHK({useInternalClk, vcxoFromPackets, clkFromSysTime, srcBypass}, 4'b1100)
    `CHK({auxBaud, auxRxEnable}, 4'b0001)
    rd(OFS_CTRL, CTRL_RESET);
    rd(OFS_CLIP, CLIP_RESET);
    wr(OFS_CLIP, 32'h0000_0096);
    rd(OFS_CLIP, 32'h0000_0096);
    rd(8'h40, 32'h0000_0000, 1'b1);
  endtask : t_reset

  task automatic t_enc();
    wr(OFS_CTRL, 32'h0000_0143); `CHK(srcBypass, 1'b1)
    wr(OFS_CTRL, 32'h0000_0141); `CHK(srcBypass, 1'b0)
    wr(OFS_CTRL, 32'h0000_0142); `CHK(srcBypass, 1'b0)
    encLeft <= 24'h7F_FFFF; encRight <= 24'h7F_FFFD;
    wr(OFS_CTRL, 32'h0000_014C); `CHK(encMonoSrc, 24'h7F_FFFE)
    wr(OFS_CTRL, 32'h0000_0148); `CHK(encMonoSrc, 24'h7F_FFFF)
    wr(OFS_CTRL, 32'h0000_0144); `CHK(encMonoSrc, 24'h7F_FFFF)
  endtask : t_enc

  task automatic t_route();
    logic [SW-1:0] p [3];
    netL <= 24'h12_3456; netR <= 24'h80_0010;
    wr(OFS_CTRL, 32'h0000_0140);
    wr(OFS_ROUTE, 32'h0000_0000); `CHK({outC, outD}, {24'h12_3456, 24'h80_0010})
    p[0] = 24'h12_3456;
    p[1] = 24'h80_0010;
    p[2] = 24'hC9_1A33;   // Signed halved sum of the two samples above
    for (int c = 0; c < 3; c++) begin
      for (int d = 0; d < 3; d++) begin
        wr(OFS_ROUTE, 32'(d * 8 + c * 2 + 1));
        `CHK({outC, outD}, {p[c], p[d]})
      end
    end
    wr(OFS_ROUTE, 32'h0000_0000);
    netMono <= 1;
    wr(OFS_CTRL, 32'h0000_0150); `CHK({outC, outD}, {p[0], 24'h00_0000})
    wr(OFS_CTRL, 32'h0000_0170); `CHK({outC, outD}, {p[0], p[0]})
    netMono <= 0;
    wr(OFS_CTRL, 32'h0000_0170); `CHK({outC, outD}, {p[0], p[1]})
    wr(OFS_ROUTE, 32'h0000_0001); rd(OFS_CTRL, 32'h0000_0150);
    wr(OFS_CTRL, 32'h0000_0170); rd(OFS_CTRL, 32'h0000_0150);
    wr(OFS_ROUTE, 32'h0000_0000);
  endtask : t_route

  task automatic t_clock();
    wr(OFS_CTRL, 32'h0000_0140); `CHK({useInternalClk, vcxoFromPackets, clkFromSysTime}, 3'b110)
    wr(OFS_CTRL, 32'h0000_0340); `CHK({useInternalClk, vcxoFromPackets, clkFromSysTime}, 3'b100)
    wr(OFS_CTRL, 32'h0000_0540); `CHK({useInternalClk, vcxoFromPackets, clkFromSysTime}, 3'b100)
    wr(OFS_CTRL, 32'h0000_0D40); `CHK({vcxoFromPackets, clkFromSysTime}, 2'b01)
    wr(OFS_CTRL, 32'h0000_0140);
  endtask : t_clock

  task automatic t_aux();
    logic [3:0] w [4] = '{4'h7, 4'hF, 4'hA, 4'h0};
    logic [3:0] x [4] = '{4'hF, 4'h6, 4'h4, 4'h1};   // {baud, receive enabled}
    for (int i = 0; i < 4; i++) begin
      wr(OFS_AUX, {28'h000_0000, w[i]});
      `CHK({auxBaud, auxRxEnable}, x[i])
    end
    wr(OFS_STATUS, 32'hFFFF_FFFF);
    rd(OFS_STATUS, 32'h0000_0016);
    rd(OFS_IRQ_CLR, 32'h0000_0000);
  endtask : t_aux

  task automatic t_alarm();
    wr(OFS_IRQ_EN, 32'h0000_000F);
    wr(OFS_FAILTIME, 32'h0000_000A);
    hold(4'h1, 10); rd(OFS_IRQ_STAT, 32'h0000_0000);
    hold(4'h1, 8); hold(4'h1, 8); rd(OFS_IRQ_STAT, 32'h0000_0000);
    hold(4'h1, 20); rd(OFS_IRQ_STAT, 32'h0000_0001);
    `CHK(irq, 1'b1)
    wr(OFS_IRQ_CLR, 32'h0000_0001); `CHK(irq, 1'b0)
    hold(4'h2, 2); rd(OFS_IRQ_STAT, 32'h0000_0002);
    wr(OFS_IRQ_EN, 32'h0000_0000); `CHK(irq, 1'b0)
    wr(OFS_IRQ_EN, 32'h0000_000F); `CHK(irq, 1'b1)
    wr(OFS_IRQ_CLR, 32'h0000_000F);
    wr(OFS_CTRL, 32'h0000_0040); hold(4'h2, 2); rd(OFS_IRQ_STAT, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0100); hold(4'h4, 2); rd(OFS_IRQ_STAT, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_0140); hold(4'h4, 2); rd(OFS_IRQ_STAT, 32'h0000_0004);
    wr(OFS_IRQ_CLR, 32'h0000_000F);
    hold(4'h8, 2); rd(OFS_IRQ_STAT, 32'h0000_0000);
    wr(OFS_CTRL, 32'h0000_01C0); hold(4'h8, 2); rd(OFS_IRQ_STAT, 32'h0000_0008);
  endtask : t_alarm

  // Main sequence: reset for 16 cycles, then every scenario once
  initial begin
    repeat (16) @(posedge sys_clk);
    arst_n <= 1;
    t_reset();
    t_enc();
    t_route();
    t_clock();
    t_aux();
    t_alarm();
    finish_test();
  end
endmodule : car_route_alarm_tb
